// [stind_blink.sv]
// Millisecond tick and blink pattern generator
`timescale 1ns/1ps
module stind_blink
  import stind_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Patterns
  output logic      flash,
  output logic      single,
  output logic      flicker
);

  logic [15:0] div;
  logic        tick;
  logic [10:0] ms;
  logic [7:0]  fl_cnt;
  logic [6:0]  fk_cnt;

  // ----------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn || div == 16'(TICK_CYCLES - 1)) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    tick <= rstn && div == 16'(TICK_CYCLES - 1);
  end

  // ----------------------------------------------------------------
  // Pattern counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ms      <= 11'h000;
      fl_cnt  <= 8'h00;
      fk_cnt  <= 7'h00;
      flash   <= 1'b0;
      single  <= 1'b0;
      flicker <= 1'b0;
    end else if (tick) begin
      ms <= (ms == 11'(SINGLE_PER_MS - 1)) ? 11'h000 : ms + 11'h001;
      single <= ms < 11'(SINGLE_ON_MS - 1) ||
                ms == 11'(SINGLE_PER_MS - 1);
      if (fl_cnt == 8'((flash ? FLASH_ON_MS : FLASH_OFF_MS) - 1)) begin
        fl_cnt <= 8'h00;
        flash  <= ~flash;
      end else begin
        fl_cnt <= fl_cnt + 8'h01;
      end
      if (fk_cnt == 7'((flicker ? FLICK_ON_MS : FLICK_OFF_MS) - 1)) begin
        fk_cnt  <= 7'h00;
        flicker <= ~flicker;
      end else begin
        fk_cnt <= fk_cnt + 7'h01;
      end
    end
  end

endmodule // stind_blink

// [stind_far.sv]
// Encoder-side model feeding channel data, activity and clocks
`timescale 1ns/1ps
module stind_far (
  // Clock
  input  wire logic       clk,
  // Encoder outputs
  output logic      [3:0] enc_data,
  output logic      [3:0] enc_active,
  output logic      [1:0] enc_clk
);
  logic [9:0] s = 10'h155;
  // Changes every cycle, so a stale pin value shows at once
  always_ff @(posedge clk) s <= s * 10'h005 + 10'h0C7;
  assign {enc_data, enc_active, enc_clk} = s;
endmodule // stind_far

// [stind_pkg.sv]
// Package of constants for the status indicator block
package stind_pkg;

  // ----------------------------------------------------------------
  // Fieldbus state codes
  // ----------------------------------------------------------------
  localparam logic [3:0] ST_INIT      = 4'h1;
  localparam logic [3:0] ST_PREOP     = 4'h2;
  localparam logic [3:0] ST_BOOTSTRAP = 4'h3;
  localparam logic [3:0] ST_SAFEOP    = 4'h4;
  localparam logic [3:0] ST_OP        = 4'h8;

  // ----------------------------------------------------------------
  // Register map (word addresses on the plain port)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ    = 4'h2;
  localparam logic [3:0] REG_MASK   = 4'h3;

  // Control register fields
  localparam int CTRL_CLOCKED = 0;
  localparam int CTRL_WARN    = 1;
  localparam int CTRL_ERR     = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // Interrupt status bits
  localparam int IRQ_STATE  = 0;
  localparam int IRQ_SUPPLY = 1;
  localparam int IRQ_WARN   = 2;
  localparam int IRQ_ERR    = 3;

  // ----------------------------------------------------------------
  // Blink timing, 10 MHz clock, times in ms
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 10_000_000;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int FLASH_ON_MS  = 200;
  localparam int FLASH_OFF_MS = 200;
  localparam int SINGLE_ON_MS = 200;
  localparam int SINGLE_PER_MS = 1200;
  localparam int FLICK_ON_MS  = 50;
  localparam int FLICK_OFF_MS = 50;

endpackage

// [stind_props.sv]
// Checker of lamps and channel pins
`timescale 1ns/1ps
module stind_props
  import stind_pkg::*;
(
  // Clock, reset and inputs
  input wire logic       clk, rstn, supply_ok, warn_in, err_in, wr,
  input wire logic [3:0] bus_state, enc_data, enc_active, addr,
  input wire logic [1:0] enc_clk,
  input wire logic [7:0] wdata,
  // Outputs
  input wire logic       led_run, led_supply, led_warn, led_err,
  input wire logic [3:0] ch_pin, led_act
);
  logic op, cm, p2, p4;
  assign op = rstn && bus_state == ST_OP;
  // Expected shared pins from the last written protocol bit
  always_ff @(posedge clk) begin
    p2 <= cm ? enc_clk[0] : enc_data[1];
    p4 <= cm ? enc_clk[1] : enc_data[3];
    if (!rstn) cm <= 1'b0;
    else if (wr && addr == REG_CTRL) cm <= wdata[CTRL_CLOCKED];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_run_lit:
    assert property (op |=> led_run) else $error("run dark");
  a_run_dark:
    assert property (rstn && bus_state == ST_INIT |=> !led_run)
    else $error("run lit");
  a_safe_pins:
    assert property (rstn && bus_state == ST_SAFEOP |=> !ch_pin && !led_act)
    else $error("pins driven");
  a_supply_lamp:
    assert property (rstn |=> led_supply == $past(supply_ok))
    else $error("supply lamp");
  a_act_lamps:
    assert property (op |=> led_act == $past(enc_active))
    else $error("activity lamps");
  a_pin_two:
    assert property (op |=> ch_pin[1] == p2) else $error("pin two");
  a_pin_four:
    assert property (op |=> ch_pin[3] == p4) else $error("pin four");
  a_warn_lamp:
    assert property (rstn && warn_in |=> led_warn) else $error("warn dark");
  a_err_lamp:
    assert property (rstn && err_in |=> led_err) else $error("error dark");
endmodule // stind_props

bind stind_top stind_props u_stind_props (.clk, .rstn, .supply_ok, .warn_in,
  .err_in, .wr, .bus_state, .enc_data, .enc_active, .addr, .enc_clk, .wdata,
  .led_run, .led_supply, .led_warn, .led_err, .ch_pin, .led_act);

// [stind_top.sv]
// Front-panel status indicators and channel pin sharing
//
// Behaviour
// - Run lamp: off INIT, flash PREOP, single SAFEOP, on OP, flicker BOOT.
// - In SAFEOP all data and clock pins hold their safe low level.
// - Supply lamp lit only while internal supply is reported good.
// - Each channel's activity lamp lit in OP while its data output is active.
// - Channel two pin is clock one when clocked protocol, else data two.
// - Channel four pin is clock two when clocked protocol, else data four.
`timescale 1ns/1ps
module stind_top
  import stind_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Fieldbus state, supply, warning and error inputs
  input  wire logic [3:0] bus_state,
  input  wire logic       supply_ok,
  input  wire logic       warn_in,
  input  wire logic       err_in,
  // Protocol encoder outputs
  input  wire logic [3:0] enc_data,
  input  wire logic [3:0] enc_active,
  input  wire logic [1:0] enc_clk,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            irq,
  // Channel pins
  output logic      [3:0] ch_pin,
  // Indicator lamps
  output logic            led_run,
  output logic            led_supply,
  output logic            led_warn,
  output logic            led_err,
  output logic      [3:0] led_act
);

  logic [7:0] ctrl;
  logic [7:0] mask;
  logic [3:0] irq_stat;
  logic [3:0] next_irq_stat;
  logic [3:0] ev;
  logic [3:0] prev_state;
  logic       prev_supply;
  logic       prev_warn;
  logic       prev_err;
  logic       flash;
  logic       single;
  logic       flicker;
  logic       safe;
  logic       clocked;
  logic       warn;
  logic       err;

  function automatic logic run_lamp(input logic [3:0] st,
                                    input logic fl, input logic sg,
                                    input logic fk);
    case (st)
      ST_PREOP:     run_lamp = fl;
      ST_SAFEOP:    run_lamp = sg;
      ST_OP:        run_lamp = 1'b1;
      ST_BOOTSTRAP: run_lamp = fk;
      default:      run_lamp = 1'b0;
    endcase
  endfunction

  stind_blink u_blink (
    .clk     (clk),
    .rstn    (rstn),
    .flash   (flash),
    .single  (single),
    .flicker (flicker)
  );

  assign safe    = bus_state != ST_OP;
  assign clocked = ctrl[CTRL_CLOCKED];
  assign warn    = warn_in | ctrl[CTRL_WARN];
  assign err     = err_in | ctrl[CTRL_ERR];

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
      mask <= MASK_RESET;
    end else if (wr) begin
      if (addr == REG_CTRL) begin
        ctrl <= wdata;
      end
      if (addr == REG_MASK) begin
        mask <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        REG_CTRL:   rdata <= ctrl;
        REG_STATUS: rdata <= {supply_ok, err, warn, 1'b0, bus_state};
        REG_IRQ:    rdata <= {4'h0, irq_stat};
        REG_MASK:   rdata <= mask;
        default:    rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: set wins over clear on read
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_state  <= ST_INIT;
      prev_supply <= 1'b0;
      prev_warn   <= 1'b0;
      prev_err    <= 1'b0;
    end else begin
      prev_state  <= bus_state;
      prev_supply <= supply_ok;
      prev_warn   <= warn;
      prev_err    <= err;
    end
  end

  always_comb begin
    ev = 4'h0;
    ev[IRQ_STATE]  = bus_state != prev_state;
    ev[IRQ_SUPPLY] = supply_ok != prev_supply;
    ev[IRQ_WARN]   = warn & ~prev_warn;
    ev[IRQ_ERR]    = err & ~prev_err;
    next_irq_stat = irq_stat;
    if (rd && addr == REG_IRQ) begin
      next_irq_stat = 4'h0;
    end
    next_irq_stat = next_irq_stat | ev;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_stat <= 4'h0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq      <= |(next_irq_stat & mask[3:0]);
    end
  end

  // ----------------------------------------------------------------
  // Channel pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn || safe) begin
      ch_pin <= 4'h0;
    end else begin
      ch_pin[0] <= enc_data[0];
      ch_pin[2] <= enc_data[2];
      ch_pin[1] <= clocked ? enc_clk[0] : enc_data[1];
      ch_pin[3] <= clocked ? enc_clk[1] : enc_data[3];
    end
  end

  // ----------------------------------------------------------------
  // Lamps
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      led_run    <= 1'b0;
      led_supply <= 1'b0;
      led_warn   <= 1'b0;
      led_err    <= 1'b0;
      led_act    <= 4'h0;
    end else begin
      led_run    <= run_lamp(bus_state, flash, single, flicker);
      led_supply <= supply_ok;
      led_warn   <= warn;
      led_err    <= err;
      // Activity lamps follow enc_active in OP, clock-carrying pins included
      led_act    <= safe ? 4'h0 : enc_active;
    end
  end

endmodule // stind_top

// [tb.sv]
// Self-checking bench of the status indicator block
`timescale 1ns/1ps
module tb
  import stind_pkg::*;
;
  logic       clk, rstn, supply_ok, warn_in, err_in, wr, rd, m, irq;
  logic       led_run, led_supply, led_warn, led_err;
  logic [3:0] bus_state, addr, enc_data, enc_active, ch_pin, led_act;
  logic [1:0] enc_clk;
  logic [2:0] f;
  logic [7:0] wdata, rdata, d;
  int         failures = 0;
  int         comparisons = 0;
  stind_top u_stind_top (.clk, .rstn, .bus_state, .supply_ok, .warn_in,
    .err_in, .enc_data, .enc_active, .enc_clk, .addr, .wdata, .wr, .rd,
    .rdata, .irq, .ch_pin, .led_run, .led_supply, .led_warn, .led_err,
    .led_act);
  stind_far u_stind_far (.clk, .enc_data, .enc_active, .enc_clk);
  always #50 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  // Register cycle; read data taken in the cycle after the strobe
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    {wr, rd, addr, wdata} <= {w, !w, a, v};
    @(posedge clk);
    {wr, rd} <= 2'h0;
    #1 d = rdata;
  endtask
  function automatic logic [7:0] lamps();
    return {4'h0, supply_ok, warn_in | f[1], err_in | f[2],
            m && bus_state == ST_OP};
  endfunction
  task automatic print_verdict();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Run needs about 11,000 cycles, most of it waiting for the first tick
  initial begin
    #3_000_000;
    failures++;
    print_verdict();
  end
  initial begin
    {clk, rstn, supply_ok, warn_in, err_in, wr, rd} = 7'h00;
    {bus_state, addr, wdata, f} = {ST_INIT, 4'h0, 8'h00, 3'h0};
    void'($urandom(82988));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 chk({ch_pin, led_act}, 8'h00);
    for (int i = 0; i < 150; i++) begin
      f = 3'($urandom);
      acc(1'b1, REG_CTRL, {5'h00, f});
      bus_state <= 4'($urandom_range(8));
      {supply_ok, warn_in, err_in} <= 3'($urandom);
      repeat (2) @(posedge clk);
      #1 m = !(bus_state inside {ST_PREOP, ST_SAFEOP, ST_BOOTSTRAP});
      d = {4'h0, led_supply, led_warn, led_err, led_run && m};
      chk(d, lamps());
      if (bus_state != ST_OP) chk({ch_pin, led_act}, 8'h00);
    end
    acc(1'b1, 4'h7, 8'h02);
    acc(1'b0, REG_CTRL, 8'h00);
    chk(d, {5'h00, f});
    acc(1'b0, 4'h7, 8'h00);
    chk(d, 8'h00);
    acc(1'b1, REG_CTRL, 8'h00);
    acc(1'b0, REG_STATUS, 8'h00);
    chk(d, {supply_ok, err_in, warn_in, 1'b0, bus_state});
    acc(1'b1, REG_MASK, 8'h05);
    bus_state <= ST_INIT;
    // Each event in turn; events 0 and 2 unmasked
    for (int k = 0; k < 4; k++) begin
      {warn_in, err_in} <= 2'h0;
      repeat (2) @(posedge clk);
      acc(1'b0, REG_IRQ, 8'h00);
      if (k == 0) bus_state <= ST_OP;
      if (k == 1) supply_ok <= !supply_ok;
      if (k == 2) warn_in <= 1'b1;
      if (k == 3) err_in <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({7'h00, irq}, {7'h00, !k[0]});
      acc(1'b0, REG_IRQ, 8'h00);
      chk(d, 8'h01 << k);
      @(posedge clk);
      #1 chk({7'h00, irq}, 8'h00);
    end
    // Single flash is lit once the first millisecond tick has passed
    bus_state <= ST_SAFEOP;
    repeat (TICK_CYC) @(posedge clk);
    #1 chk({7'h00, led_run}, 8'h01);
    chk({ch_pin, led_act}, 8'h00);
    print_verdict();
  end
endmodule // tb
